// *** bridge_fault_map.svh ***
// register offsets, field positions, reset values and timing counts
// for the bridge fault-action block; included by its design files
`ifndef BRIDGE_FAULT_MAP_SVH
`define BRIDGE_FAULT_MAP_SVH

// byte offsets on the register bus, one aligned word each
`define OFS_CONFIG     5'h00
`define OFS_MASK       5'h04
`define OFS_DIAG       5'h08
`define OFS_VERIFY     5'h0C
`define OFS_GATE       5'h10
`define OFS_IRQ_STAT   5'h14
`define OFS_IRQ_MASK   5'h18

// configuration fields
`define CFG_ESF_BIT    0
`define CFG_EWD_BIT    1
`define CFG_QMODE_BIT  2
`define CFG_QTIME_LSB  8
`define CFG_QTIME_MSB  13
`define CONFIG_RST     32'h00000F00

// diagnostic bits; the mask register has the same layout
`define DG_DS_LSB      0
`define DG_BSU_LSB     4
`define DG_VREG_UV     8
`define DG_LOGIC_OV    9
`define DG_WD          10
`define DG_OT          11
`define DG_SER         12
`define DG_VBB_UV      14
`define DG_W           20
`define MASK_WRITABLE  32'h000FE7FF

// verification result bits
`define VF_PHASE_LSB   4
`define VF_W           3

// gate status fields
`define GT_LAT_LSB     4
`define GT_GOFF_BIT    8

// interrupt status bits
`define IRQ_DIAG       0
`define IRQ_VERIFY     1
`define IRQ_SHUT       2
`define IRQ_W          3

// qualifier step and core clock period, both in ns
`define QUAL_UNIT_NS   100
`define CLK_PERIOD_NS  40

`endif

// *** bridge_fault_pkg.sv ***
// types shared by the bridge fault-action design files
// assumes nothing of its surroundings
package bridge_fault_pkg;
  typedef enum logic {QUAL_DEBOUNCE, QUAL_BLANK} qual_mode_e;
  typedef logic [3:0] sw_vec_t;
endpackage : bridge_fault_pkg

// *** sync2.sv ***
// two-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk, // core clock
  input  wire logic         i_nrst,    // async reset, active low
  input  wire logic [W-1:0] i_d,       // asynchronous levels
  output logic      [W-1:0] o_q        // synchronised levels
);
  logic [W-1:0] meta;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule : sync2
`default_nettype wire

// *** ds_qualifier.sv ***
// drain-source fault qualifier for one switch: debounce or blanking timer
// assumes synchronised comparator and the switch's registered drive state
`timescale 1ns/1ps
`default_nettype none
`include "bridge_fault_map.svh"
module ds_qualifier (
  input  wire logic                          i_ref_clk, // core clock
  input  wire logic                          i_nrst,    // async reset, active low
  input  wire logic                          i_cmp,     // comparator says overvoltage
  input  wire logic                          i_active,  // switch is being driven on
  input  wire bridge_fault_pkg::qual_mode_e  i_mode,    // debounce or blanking
  input  wire logic                    [5:0] i_time,    // qualifier time setting
  output logic                               o_valid    // qualified fault
);
  import bridge_fault_pkg::*;

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       act_q;
  logic       next_valid;
  logic [7:0] target;
  logic [7:0] cnt_inc;

  always_comb begin
    // least time, so round the setting up to whole clock cycles
    target  = 8'(((32'(i_time) * `QUAL_UNIT_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
    cnt_inc = (cnt == 8'hFF) ? cnt : cnt + 8'h01;
    if (i_mode == QUAL_DEBOUNCE) begin
      next_cnt = (i_cmp && i_active) ? cnt_inc : 8'h00;
    end else begin
      next_cnt = (i_active && !act_q) ? 8'h00 : cnt_inc;
    end
    // in blanking the turn-on cycle itself must not qualify on a stale count
    next_valid = i_cmp && i_active && (cnt >= target)
              && (i_mode == QUAL_DEBOUNCE || act_q);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt     <= 8'h00;
      act_q   <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      act_q   <= i_active;
      o_valid <= next_valid;
    end
  end

  property p_qual_timer;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_valid |-> ($past(cnt) >= $past(target)) && $past(i_cmp);
  endproperty
  a_qual_timer: assert property (p_qual_timer) else $error("fault qualified early");

  property p_blank_turn_on;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (i_mode == QUAL_BLANK && i_active && !act_q && target > 8'h01) |=> !o_valid;
  endproperty
  a_blank_turn_on: assert property (p_blank_turn_on) else $error("blanking not applied");
endmodule : ds_qualifier
`default_nettype wire

// *** bridge_fault_action_logic.sv ***
// fault-action and fault-latch logic of a full-bridge gate driver,
// with sticky diagnostic bits, masks and an Avalon-MM register slave
// assumes detector levels arrive asynchronously on pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "bridge_fault_map.svh"
module bridge_fault_action_logic (
  input  wire logic                       i_ref_clk,             // core clock, 25 MHz
  input  wire logic                       i_nrst,                // power-on reset, active low
  input  wire logic                 [4:0] i_avs_address,         // byte address
  input  wire logic                       i_avs_read,            // read request
  input  wire logic                       i_avs_write,           // write request
  input  wire logic                [31:0] i_avs_writedata,       // write data
  input  wire logic                 [3:0] i_avs_byteenable,      // byte lanes
  output logic                     [31:0] o_avs_readdata,        // read data
  output logic                            o_avs_waitrequest,     // stall
  input  wire bridge_fault_pkg::sw_vec_t  i_gate_cmd,            // switch on commands
  input  wire bridge_fault_pkg::sw_vec_t  i_ds_cmp,              // drain-source comparators
  input  wire bridge_fault_pkg::sw_vec_t  i_boot_uv,             // bootstrap undervoltage
  input  wire logic                       i_vreg_uv,             // regulator undervoltage
  input  wire logic                       i_logic_ov,            // logic terminal overvoltage
  input  wire logic                       i_wd_timeout,          // enable watchdog expired
  input  wire logic                       i_overtemp,            // overtemperature
  input  wire logic                       i_ser_err,             // serial transmission error
  input  wire logic                       i_vreg_ov,             // regulator overvoltage
  input  wire logic                       i_vbb_uv,              // supply undervoltage
  input  wire logic                       i_vbb_ov,              // supply overvoltage
  input  wire logic                       i_vgs_uv,              // gate-source undervoltage
  input  wire logic                       i_temp_warn,           // temperature warning
  input  wire logic                       i_overcurrent,         // overcurrent
  input  wire logic                       i_open_load,           // open load
  input  wire logic                       i_vbrg_open,           // bridge reference open
  input  wire logic                       i_lss_open,            // low-side source open
  input  wire logic                       i_sense_open,          // sense amp input open
  input  wire logic                 [1:0] i_phase_state,         // phase state monitor
  input  wire logic                       i_fault_clear_input_n, // fault clear, active low
  output bridge_fault_pkg::sw_vec_t       o_gate_drive,          // gate enables to drivers
  output logic                            o_irq                  // interrupt, active high
);
  import bridge_fault_pkg::*;

  localparam int SW = 30;

  logic [SW-1:0] sync_q;
  sw_vec_t       s_cmd, s_cmp, s_bsu;
  logic          s_vreg_uv, s_logic_ov, s_wd, s_ot, s_ser, s_vreg_ov;
  logic          s_vbb_uv, s_vbb_ov, s_vgs_uv, s_tw, s_oc, s_ol;
  logic          s_vbrg, s_lss, s_sense, s_clr_n;
  logic [1:0]    s_phase;

  logic [31:0]        config_r, mask, irq_mask;
  logic [`DG_W-1:0]   diag;
  logic [`VF_W-1:0]   verify;
  logic [`IRQ_W-1:0]  irq_stat;
  sw_vec_t            latched, cmd_q, ds_valid;
  logic               goff_q;

  logic [31:0]        next_config, next_mask, next_irq_mask, next_rdata;
  logic [`DG_W-1:0]   next_diag, dset, draw;
  logic [`VF_W-1:0]   next_verify, vset;
  logic [`IRQ_W-1:0]  next_irq_stat;
  sw_vec_t            next_latched, next_gate, sw_hit, cmd_rise, lat_clr;
  logic               next_goff, next_irq, next_wait;
  logic [31:0]        w1c;
  logic               stop_on_fault_select, enable_watchdog_on, rd_acc, wr_acc, diag_rd, verify_rd;
  qual_mode_e         qmode;

  sync2 #(.W(SW)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_d       ({i_gate_cmd, i_ds_cmp, i_boot_uv, i_vreg_uv, i_logic_ov, i_wd_timeout,
                 i_overtemp, i_ser_err, i_vreg_ov, i_vbb_uv, i_vbb_ov, i_vgs_uv,
                 i_temp_warn, i_overcurrent, i_open_load, i_vbrg_open, i_lss_open,
                 i_sense_open, i_phase_state, i_fault_clear_input_n}),
    .o_q       (sync_q)
  );

  assign {s_cmd, s_cmp, s_bsu, s_vreg_uv, s_logic_ov, s_wd, s_ot, s_ser, s_vreg_ov,
          s_vbb_uv, s_vbb_ov, s_vgs_uv, s_tw, s_oc, s_ol, s_vbrg, s_lss, s_sense,
          s_phase, s_clr_n} = sync_q;

  assign stop_on_fault_select   = config_r[`CFG_ESF_BIT];
  assign enable_watchdog_on   = config_r[`CFG_EWD_BIT];
  assign qmode = config_r[`CFG_QMODE_BIT] ? QUAL_BLANK : QUAL_DEBOUNCE;

  // qualifier watches the driven state, so a switched-off fet restarts its timer
  for (genvar i = 0; i < 4; i++) begin : g_qual
    ds_qualifier u_qual (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_cmp     (s_cmp[i]),
      .i_active  (o_gate_drive[i]),
      .i_mode    (qmode),
      .i_time    (config_r[`CFG_QTIME_MSB:`CFG_QTIME_LSB]),
      .o_valid   (ds_valid[i])
    );
  end

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // fault detection, latching and gate action
  always_comb begin
    draw = {s_ol, s_oc, s_tw, s_vgs_uv, s_vbb_ov, s_vbb_uv, s_vreg_ov, s_ser, s_ot,
            s_wd, s_logic_ov, s_vreg_uv, s_bsu, ds_valid};
    dset = draw & ~mask[`DG_W-1:0];
    sw_hit = dset[`DG_DS_LSB +: 4] | dset[`DG_BSU_LSB +: 4];
    cmd_rise = s_cmd & ~cmd_q;
    lat_clr = {4{!s_clr_n || diag_rd}};
    if (!stop_on_fault_select) begin
      lat_clr = lat_clr | cmd_rise;
    end
    next_latched = (latched & ~lat_clr) | sw_hit;
    // level faults act only while present; warnings never stop the bridge
    next_goff = dset[`DG_VREG_UV] || dset[`DG_VBB_UV]
             || (enable_watchdog_on && dset[`DG_WD])
             || (stop_on_fault_select && (dset[`DG_LOGIC_OV] || dset[`DG_OT]))
             || (stop_on_fault_select && (|(latched | sw_hit)));
    next_gate = s_cmd & ~{4{next_goff}};
    if (!stop_on_fault_select) begin
      next_gate = next_gate & ~(latched | sw_hit);
    end
  end

  // bus handshake: one wait cycle, then accept
  always_comb begin
    rd_acc    = i_avs_read && !o_avs_waitrequest;
    wr_acc    = i_avs_write && !o_avs_waitrequest;
    diag_rd   = rd_acc && (i_avs_address == `OFS_DIAG);
    verify_rd = rd_acc && (i_avs_address == `OFS_VERIFY);
    next_wait = !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    next_rdata = o_avs_readdata;
    if (i_avs_read && o_avs_waitrequest) begin
      if (i_avs_address == `OFS_CONFIG) begin
        next_rdata = config_r;
      end else if (i_avs_address == `OFS_MASK) begin
        next_rdata = mask;
      end else if (i_avs_address == `OFS_DIAG) begin
        next_rdata = 32'(diag);
      end else if (i_avs_address == `OFS_VERIFY) begin
        next_rdata = 32'({s_phase, 1'b0, verify});
      end else if (i_avs_address == `OFS_GATE) begin
        next_rdata = 32'({goff_q, latched, o_gate_drive});
      end else if (i_avs_address == `OFS_IRQ_STAT) begin
        next_rdata = 32'(irq_stat);
      end else if (i_avs_address == `OFS_IRQ_MASK) begin
        next_rdata = irq_mask;
      end else begin
        next_rdata = 32'h00000000;
      end
    end
  end

  // registers, sticky bits and interrupt
  always_comb begin
    w1c           = be_merge(32'h00000000, i_avs_writedata, i_avs_byteenable);
    next_config   = config_r;
    next_mask     = mask;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_acc) begin
      if (i_avs_address == `OFS_CONFIG) begin
        next_config = be_merge(config_r, i_avs_writedata, i_avs_byteenable);
      end else if (i_avs_address == `OFS_MASK) begin
        next_mask = be_merge(mask, i_avs_writedata, i_avs_byteenable)
                  & `MASK_WRITABLE;
      end else if (i_avs_address == `OFS_IRQ_STAT) begin
        next_irq_stat = irq_stat & ~w1c[`IRQ_W-1:0];
      end else if (i_avs_address == `OFS_IRQ_MASK) begin
        next_irq_mask = be_merge(irq_mask, i_avs_writedata, i_avs_byteenable);
      end
    end
    // only the bits that were returned are cleared; a new fault wins
    next_diag = diag;
    if (diag_rd) begin
      next_diag = diag & ~o_avs_readdata[`DG_W-1:0];
    end
    next_diag = next_diag | dset;
    vset = {s_sense, s_lss, s_vbrg};
    next_verify = verify;
    if (verify_rd) begin
      next_verify = verify & ~o_avs_readdata[`VF_W-1:0];
    end
    next_verify = next_verify | vset;
    next_irq_stat[`IRQ_DIAG]   = next_irq_stat[`IRQ_DIAG] | (|(dset & ~diag));
    next_irq_stat[`IRQ_VERIFY] = next_irq_stat[`IRQ_VERIFY] | (|(vset & ~verify));
    next_irq_stat[`IRQ_SHUT]   = next_irq_stat[`IRQ_SHUT] | (next_goff & ~goff_q);
    next_irq = |(next_irq_stat & next_irq_mask[`IRQ_W-1:0]);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_gate_drive      <= 4'h0;
      latched           <= 4'h0;
      cmd_q             <= 4'h0;
      goff_q            <= 1'b1;
      diag              <= '0;
      verify            <= '0;
      config_r          <= `CONFIG_RST;
      mask              <= 32'h00000000;
      irq_mask          <= 32'h00000000;
      irq_stat          <= '0;
      o_irq             <= 1'b0;
      o_avs_readdata    <= 32'h00000000;
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_gate_drive      <= next_gate;
      latched           <= next_latched;
      cmd_q             <= s_cmd;
      goff_q            <= next_goff;
      diag              <= next_diag;
      verify            <= next_verify;
      config_r          <= next_config;
      mask              <= next_mask;
      irq_mask          <= next_irq_mask;
      irq_stat          <= next_irq_stat;
      o_irq             <= next_irq;
      o_avs_readdata    <= next_rdata;
      o_avs_waitrequest <= next_wait;
    end
  end

  property p_short_bit;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      dset[`DG_DS_LSB] |=> diag[`DG_DS_LSB] && (latched[0] || !$past(stop_on_fault_select)) ##1 !o_gate_drive[0];
  endproperty
  a_short_bit: assert property (p_short_bit) else $error("short did not stop switch");

  property p_uv_off;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      dset[`DG_VREG_UV] |=> o_gate_drive == 4'h0;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage left gate on");

  property p_wd_off;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (enable_watchdog_on && dset[`DG_WD]) |=> o_gate_drive == 4'h0;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog left gate on");

  property p_ot_esf;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (stop_on_fault_select && s_ot) |=> o_gate_drive == 4'h0;
  endproperty
  a_ot_esf: assert property (p_ot_esf) else $error("overtemperature left gate on");

  property p_esf_hold;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (stop_on_fault_select && latched != 4'h0 && s_clr_n && !diag_rd) |=> latched != 4'h0 && !goff_q == 1'b0;
  endproperty
  a_esf_hold: assert property (p_esf_hold) else $error("latched stop released");

  property p_cmd_clear;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (!stop_on_fault_select && latched[0] && cmd_rise[0] && !sw_hit[0]) |=> !latched[0];
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("turn-on did not clear");

  property p_clr_input;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (!s_clr_n && sw_hit == 4'h0) |=> latched == 4'h0;
  endproperty
  a_clr_input: assert property (p_clr_input) else $error("fault clear ignored");

  property p_bits_keep;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      !diag_rd |=> (diag & $past(diag)) == $past(diag);
  endproperty
  a_bits_keep: assert property (p_bits_keep) else $error("sticky bit lost");

  property p_read_set;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      (diag_rd && dset != '0) |=> (diag & $past(dset)) == $past(dset);
  endproperty
  a_read_set: assert property (p_read_set) else $error("fault lost at read");

  property p_gate_cmd;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      o_gate_drive[0] |-> $past(s_cmd[0]) && !$past(next_goff);
  endproperty
  a_gate_cmd: assert property (p_gate_cmd) else $error("gate on without command");
endmodule : bridge_fault_action_logic
`default_nettype wire

// *** ctrl_model.sv ***
// model of the system controller's logic-input side: switch commands and fault clear
// assumes the bench asks for levels; outputs change only on the core clock
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input  wire logic                      i_ref_clk,              // core clock
  input  wire logic                      i_nrst,                 // power-on reset, active low
  input  wire logic                [3:0] i_cmd_req,              // wanted switch commands
  input  wire logic                      i_clr_req,              // wanted fault clear
  output bridge_fault_pkg::sw_vec_t      o_gate_cmd,             // switch on commands
  output logic                           o_fault_clear_input_n   // fault clear, active low
);
  import bridge_fault_pkg::*;
  // off-line checks are never commanded here, so no protection is lost
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_gate_cmd            <= '0;
      o_fault_clear_input_n <= 1'b1;
    end else begin
      o_gate_cmd            <= i_cmd_req;
      o_fault_clear_input_n <= !i_clr_req;
    end
  end
endmodule : ctrl_model
`default_nettype wire

// *** test_bridge_fault_action_logic.sv ***
// self-checking bench for the bridge fault-action block
// assumes the design's 2-flop input sync and 1-wait-cycle register bus
`timescale 1ns/1ps
`default_nettype none
`include "bridge_fault_map.svh"
module test_bridge_fault_action_logic;
  import bridge_fault_pkg::*;
  logic        clk, nrst, rd, wr, clr_req, clr_n, irq, waitreq;
  logic [4:0]  address;
  logic [31:0] wdata, rdata, d;
  logic [14:0] det; // detector levels, order as the port list
  logic [1:0]  phase;
  sw_vec_t     cmd_req, gate_cmd, ds_cmp, boot_uv, gate;
  int          n_errors, tests_run, cycles;
  int          warn_idx [7] = '{4, 5, 7, 8, 9, 10, 11};
  int          warn_bit [7] = '{12, 13, 15, 16, 17, 18, 19};

  ctrl_model u_ctrl_model (.i_ref_clk(clk), .i_nrst(nrst), .i_cmd_req(cmd_req),
    .i_clr_req(clr_req), .o_gate_cmd(gate_cmd), .o_fault_clear_input_n(clr_n));
  bridge_fault_action_logic u_bridge_fault_action_logic (.i_ref_clk(clk), .i_nrst(nrst),
    .i_avs_address(address), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_gate_cmd(gate_cmd), .i_ds_cmp(ds_cmp), .i_boot_uv(boot_uv), .i_vreg_uv(det[0]),
    .i_logic_ov(det[1]), .i_wd_timeout(det[2]), .i_overtemp(det[3]), .i_ser_err(det[4]),
    .i_vreg_ov(det[5]), .i_vbb_uv(det[6]), .i_vbb_ov(det[7]), .i_vgs_uv(det[8]),
    .i_temp_warn(det[9]), .i_overcurrent(det[10]), .i_open_load(det[11]),
    .i_vbrg_open(det[12]), .i_lss_open(det[13]), .i_sense_open(det[14]),
    .i_phase_state(phase), .i_fault_clear_input_n(clr_n), .o_gate_drive(gate), .o_irq(irq));

  task end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // one bus transfer; request held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    wdata   <= v;
    wr      <= w;
    rd      <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) check(32'h1, 32'h0);
  endtask : bus

  // three edges from pin to gate; eight leaves margin
  task settle(input int c);
    repeat (c) @(posedge clk);
  endtask : settle

  task t_global(input int idx, input logic [31:0] cfg, input sw_vec_t exp, input int b);
    bus(1'b1, `OFS_CONFIG, cfg);
    det[idx] <= 1'b1;
    settle(8);
    check(gate, exp);
    bus(1'b0, `OFS_DIAG, 0);
    check(d[b], 1'b1);
    det[idx] <= 1'b0;
    settle(8);
    check(gate, 4'hF);
    bus(1'b0, `OFS_DIAG, 0);
    check(d[b], 1'b1);
  endtask : t_global

  task t_latch_stop;
    bus(1'b1, `OFS_CONFIG, 32'h00000101);
    ds_cmp <= 4'h1;
    settle(16);
    check(gate, 4'h0);
    ds_cmp <= 4'h0;
    settle(8);
    check(gate, 4'h0);
    clr_req <= 1'b1;
    settle(2);
    clr_req <= 1'b0;
    settle(8);
    check(gate, 4'hF);
    bus(1'b0, `OFS_DIAG, 0);
    check(d[3:0], 4'h1);
    bus(1'b0, `OFS_DIAG, 0);
    check(d[3:0], 4'h0);
    boot_uv <= 4'h2;
    settle(8);
    boot_uv <= 4'h0;
    settle(8);
    check(gate, 4'h0);
    bus(1'b0, `OFS_DIAG, 0);
    check(d[7:4], 4'h2);
    settle(6);
    check(gate, 4'hF);
  endtask : t_latch_stop

  task t_latch_one;
    // ten steps of 100 ns is 25 cycles: a 10-cycle glitch must not qualify
    bus(1'b1, `OFS_CONFIG, 32'h00000A00);
    ds_cmp <= 4'h1;
    settle(10);
    ds_cmp <= 4'h0;
    settle(8);
    bus(1'b0, `OFS_DIAG, 0);
    check(d[3:0], 4'h0);
    bus(1'b1, `OFS_CONFIG, 32'h00000100);
    ds_cmp <= 4'h8;
    settle(16);
    check(gate, 4'h7);
    ds_cmp <= 4'h0;
    settle(8);
    check(gate, 4'h7);
    cmd_req <= 4'h7;
    settle(6);
    cmd_req <= 4'hF;
    settle(8);
    check(gate, 4'hF);
    bus(1'b0, `OFS_DIAG, 0);
    check(d[3:0], 4'h8);
  endtask : t_latch_one

  task t_blank;
    // blanking hides the comparator for 25 cycles after turn-on, then it qualifies
    bus(1'b1, `OFS_CONFIG, 32'h00000A04);
    cmd_req <= 4'hE;
    settle(8);
    ds_cmp  <= 4'h1;
    cmd_req <= 4'hF;
    settle(12);
    check(gate, 4'hF);
    settle(30);
    check(gate, 4'hE);
    ds_cmp  <= 4'h0;
    cmd_req <= 4'hE;
    settle(6);
    cmd_req <= 4'hF;
    settle(8);
    check(gate, 4'hF);
    bus(1'b0, `OFS_DIAG, 0);
    check(d[3:0], 4'h1);
  endtask : t_blank

  task t_mask;
    bus(1'b1, `OFS_MASK, 32'hFFFFFFFF);
    bus(1'b0, `OFS_MASK, 0);
    check(d, `MASK_WRITABLE);
    bus(1'b1, `OFS_MASK, 32'h00000100);
    det[0] <= 1'b1;
    settle(8);
    check(gate, 4'hF);
    det[0] <= 1'b0;
    bus(1'b0, `OFS_DIAG, 0);
    check(d[`DG_VREG_UV], 1'b0);
    bus(1'b1, `OFS_MASK, 0);
  endtask : t_mask

  task t_verify_irq;
    bus(1'b1, `OFS_IRQ_MASK, 0);
    bus(1'b1, `OFS_IRQ_STAT, 32'h7);
    det[14:12] <= 3'b111;
    phase   <= 2'b10;
    settle(8);
    check(gate, 4'hF);
    det[14:12] <= 3'b000;
    bus(1'b0, `OFS_VERIFY, 0);
    check(d[5:0], 6'h27);
    check(irq, 1'b0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h2);
    settle(2);
    check(irq, 1'b1);
    bus(1'b1, `OFS_IRQ_STAT, 32'h7);
    settle(2);
    check(irq, 1'b0);
  endtask : t_verify_irq

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    {nrst, rd, wr, clr_req, address, wdata, det, phase} = '0;
    {ds_cmp, boot_uv} = '0;
    cmd_req = 4'hF;
    settle(3);
    check(gate, 4'h0);
    nrst <= 1'b1;
    settle(8);
    bus(1'b0, `OFS_CONFIG, 0);
    check(d, `CONFIG_RST);
    bus(1'b0, 5'h1C, 0);
    check(d, 32'h0);
    t_global(0, 32'h100, 4'h0, `DG_VREG_UV);
    t_global(2, 32'h102, 4'h0, `DG_WD);
    t_global(1, 32'h100, 4'hF, `DG_LOGIC_OV);
    t_global(1, 32'h101, 4'h0, `DG_LOGIC_OV);
    t_global(3, 32'h101, 4'h0, `DG_OT);
    t_global(3, 32'h100, 4'hF, `DG_OT);
    t_global(6, 32'h100, 4'h0, `DG_VBB_UV);
    foreach (warn_idx[i]) t_global(warn_idx[i], 32'h101, 4'hF, warn_bit[i]);
    t_latch_stop();
    t_latch_one();
    t_blank();
    t_mask();
    t_verify_irq();
    end_sim();
  end
endmodule : test_bridge_fault_action_logic
`default_nettype wire
